/* File: gfc_defs.svh */
// Purpose: named constants for the gated frequency counter
// Assumes: included by bare name from the design files
// Notes: times are kept in their own units, counts derive from them
`ifndef GFC_DEFS_SVH
`define GFC_DEFS_SVH

// reference and timing clock rates in hertz
`define GFC_REF_HZ 16000
`define GFC_TIMING_HZ 1000
// reference division ratio, derived from the two rates
`define GFC_REF_DIV (`GFC_REF_HZ / `GFC_TIMING_HZ)
// half gate period in milliseconds and its length in timing ticks
`define GFC_GATE_HALF_MS 10
`define GFC_TICKS_PER_HALF (`GFC_GATE_HALF_MS * `GFC_TIMING_HZ / 1000)
// decade limits
`define GFC_DEC_ZERO 4'h0
`define GFC_DEC_ONE 4'h1
`define GFC_DEC_MAX 4'h9
// timing decade bit positions
`define GFC_BIT_W1 0
`define GFC_BIT_W2 1
`define GFC_BIT_W4 2
// timing decade states of the three quiescent pulses
`define GFC_TST_LATCH 4'h3
`define GFC_TST_CLEAR 4'h5
`define GFC_TST_LOAD 4'h7
// preset loaded into the displayed decades, thousands first
`define GFC_PRESET 16'h9545
// display reset value
`define GFC_DISP_RST 16'h0000

`endif

/* File: gfc_pkg.sv */
// Purpose: types shared by the gated frequency counter files
// Assumes: gfc_defs.svh holds the numeric constants
// Notes: no constants live here, only types
package gfc_pkg;

  // gate phase: counting while high, quiescent while low
  typedef enum logic [0:0] {
    GFC_QUIET = 1'b0,
    GFC_COUNT = 1'b1
  } gfc_phase_e;

  // state of one bcd decade
  typedef struct packed {
    logic [3:0] val;
  } gfc_dec_s;

  // quiescent-period control pulses
  typedef struct packed {
    logic latch_en;
    logic clear;
    logic load_b;
  } gfc_pulse_s;

  // state of the top module, apart from the reset synchroniser and the tick helper
  typedef struct packed {
    logic ref_prev;
    logic lo_prev;
    logic [3:0] div;
    gfc_phase_e phase;
    logic [15:0] disp;
  } gfc_top_s;

endpackage

/* File: gfc_decade.sv */
// Purpose: one bcd decade counter with clear, active-low preset and carry
// Assumes: rst_n is already synchronised; inc is a one-cycle strobe
// Notes: clear wins over load, load wins over counting
`timescale 1ns/1ps
`include "gfc_defs.svh"

module gfc_decade (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic inc,
  input wire logic clr,
  input wire logic load_b,
  input wire logic [3:0] preset,
  output logic [3:0] val,
  output logic carry
);

  gfc_pkg::gfc_dec_s st_q;
  gfc_pkg::gfc_dec_s st_d;

  // rollover from nine advances the next decade
  assign carry = inc & (st_q.val == `GFC_DEC_MAX);
  assign val = st_q.val;

  // next value: clear, then preset, then count
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.val = `GFC_DEC_ZERO;
    end else if (!load_b) begin
      st_d.val = preset;
    end else if (inc) begin
      if (st_q.val == `GFC_DEC_MAX) begin
        st_d.val = `GFC_DEC_ZERO;
      end else begin
        st_d.val = st_q.val + `GFC_DEC_ONE;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

endmodule

/* File: gfc_top.sv */
// Purpose: gated frequency counter with latched four-digit readout
// Assumes: ref_in and lo_in are synchronous to mclk and slower than mclk/2
// Notes: one mclk domain; pulses are decoded from registered state
`timescale 1ns/1ps
`include "gfc_defs.svh"

module gfc_top #(
  parameter int REF_DIV = `GFC_REF_DIV,
  parameter logic [15:0] PRESET = `GFC_PRESET
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic ref_in,
  input wire logic lo_in,
  output logic gate,
  output gfc_pkg::gfc_pulse_s pulse,
  output logic [15:0] disp,
  output logic [3:0] timing_state
);

  localparam logic [3:0] DIV_LAST = 4'(REF_DIV - 1);
  localparam int TICKS_HALF = `GFC_TICKS_PER_HALF;
  localparam int NDIG = 4;

  // reset release through two flip-flops
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  gfc_pkg::gfc_top_s st_q;
  gfc_pkg::gfc_top_s st_d;

  logic ref_edge;
  logic lo_edge;
  logic tick_1k;
  logic count_inc;
  logic [3:0] tdec;
  logic tdec_carry;
  logic timing_bit_weight_one;
  logic timing_bit_weight_two;
  logic timing_bit_weight_four;
  logic quiet;
  logic latch_nand_b;
  logic latch_en;
  logic clear;
  logic load_b;
  logic [3:0] tenths;
  logic tenths_carry;
  logic [NDIG:0] dig_inc;
  logic [15:0] count;

  // rising edges of the reference and of the oscillator pulses
  assign ref_edge = ref_in & ~st_q.ref_prev;
  assign lo_edge = lo_in & ~st_q.lo_prev;

  // one timing tick on every sixteenth reference edge
  assign tick_1k = ce & ref_edge & (st_q.div == DIV_LAST);

  // gating of oscillator pulses by the gate phase
  always_comb begin
    case (st_q.phase)
      gfc_pkg::GFC_COUNT: count_inc = ce & lo_edge;
      gfc_pkg::GFC_QUIET: count_inc = 1'b0;
      default: count_inc = 1'b0;
    endcase
  end

  // timing decade clocked by the 1 khz tick
  gfc_decade u_timing (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .inc(tick_1k),
    .clr(1'b0),
    .load_b(1'b1),
    .preset(`GFC_DEC_ZERO),
    .val(tdec),
    .carry(tdec_carry)
  );

  // timing decade bits feeding the pulse decoders
  assign timing_bit_weight_one = tdec[`GFC_BIT_W1];
  assign timing_bit_weight_two = tdec[`GFC_BIT_W2];
  assign timing_bit_weight_four = tdec[`GFC_BIT_W4];
  assign quiet = (st_q.phase == gfc_pkg::GFC_QUIET);

  // four-input nand for enable, inverted to give an active-high level
  assign latch_nand_b = ~(quiet & timing_bit_weight_one & timing_bit_weight_two & ~timing_bit_weight_four);
  assign latch_en = ~latch_nand_b;

  // clear at state five, load at state seven, both only while quiet
  assign clear = quiet & timing_bit_weight_one & ~timing_bit_weight_two & timing_bit_weight_four;
  assign load_b = ~(quiet & timing_bit_weight_one & timing_bit_weight_two & timing_bit_weight_four);

  // hidden tenths decade, not cleared or preset
  gfc_decade u_tenths (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .inc(count_inc),
    .clr(1'b0),
    .load_b(1'b1),
    .preset(`GFC_DEC_ZERO),
    .val(tenths),
    .carry(tenths_carry)
  );

  assign dig_inc[0] = tenths_carry;

  // four displayed decades, each advanced by the carry below it
  genvar gi;
  generate
    for (gi = 0; gi < NDIG; gi++) begin : g_dig
      gfc_decade u_dig (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .inc(dig_inc[gi]),
        .clr(clear),
        .load_b(load_b),
        .preset(PRESET[gi*4 +: 4]),
        .val(count[gi*4 +: 4]),
        .carry(dig_inc[gi+1])
      );
    end
  endgenerate

  // next state: edge history, reference divider, gate toggle, latches
  always_comb begin
    st_d = st_q;
    st_d.ref_prev = ref_in;
    st_d.lo_prev = lo_in;
    if (ref_edge) begin
      if (st_q.div == DIV_LAST) begin
        st_d.div = 4'h0;
      end else begin
        st_d.div = st_q.div + 4'h1;
      end
    end
    if (tdec_carry) begin
      case (st_q.phase)
        gfc_pkg::GFC_COUNT: st_d.phase = gfc_pkg::GFC_QUIET;
        gfc_pkg::GFC_QUIET: st_d.phase = gfc_pkg::GFC_COUNT;
        default: st_d.phase = gfc_pkg::GFC_QUIET;
      endcase
    end
    if (latch_en) begin
      st_d.disp = count;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.ref_prev <= 1'b0;
      st_q.lo_prev <= 1'b0;
      st_q.div <= 4'h0;
      st_q.phase <= gfc_pkg::GFC_QUIET;
      st_q.disp <= `GFC_DISP_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // outputs
  assign gate = (st_q.phase == gfc_pkg::GFC_COUNT);
  assign pulse.latch_en = latch_en;
  assign pulse.clear = clear;
  assign pulse.load_b = load_b;
  assign disp = st_q.disp;
  assign timing_state = tdec;

  // helper: timing ticks seen since the last gate toggle
  logic [7:0] half_ticks_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_ticks_q <= 8'h00;
    end else if (tdec_carry) begin
      half_ticks_q <= 8'h00;
    end else if (tick_1k) begin
      half_ticks_q <= half_ticks_q + 8'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // the divider advances by one on each reference edge below its last count
  ref_div_a: assert property (ce && ref_edge && st_q.div != DIV_LAST |=> st_q.div == $past(st_q.div) + 4'h1)
    else $error("reference divider did not advance");

  // a timing tick only on the last divider count
  tick_div_a: assert property (tick_1k |=> st_q.div == 4'h0 && $changed(tdec))
    else $error("timing tick without divider wrap");

  // the gate flips when the timing decade rolls from nine
  gate_toggle_a: assert property (ce && tick_1k && tdec == `GFC_DEC_MAX |=> gate != $past(gate))
    else $error("gate did not toggle on timing rollover");

  // the gate holds for all other ticks
  gate_hold_a: assert property (tick_1k && tdec != `GFC_DEC_MAX |=> $stable(gate))
    else $error("gate changed without timing rollover");

  // each gate half lasts ten timing ticks
  half_len_a: assert property (tdec_carry |-> half_ticks_q == 8'(TICKS_HALF - 1))
    else $error("gate half has wrong length");

  // nothing is counted while the gate is low
  count_block_a: assert property (!gate |=> $stable(tenths))
    else $error("pulse counted while quiet");

  // a pulse in the counting half advances the tenths decade
  count_pass_a: assert property (ce && gate && lo_edge |=> tenths != $past(tenths))
    else $error("pulse lost while counting");

  // tenths rollover advances the lowest shown digit
  cascade_a: assert property (count_inc && tenths == `GFC_DEC_MAX |=> count[3:0] != $past(count[3:0]))
    else $error("carry into shown decades lost");

  // the display never moves while counting
  disp_frozen_a: assert property (gate |=> $stable(disp))
    else $error("display changed while counting");

  // enable is exactly quiet and timing state three
  latch_dec_a: assert property (latch_en == (!gate && tdec == `GFC_TST_LATCH))
    else $error("enable decode wrong");

  // enable copies the running count into the display
  latch_copy_a: assert property (ce && latch_en |=> disp == $past(count))
    else $error("display not updated by enable");

  // clear zeroes the shown decades at state five
  clear_a: assert property (ce && clear |-> tdec == `GFC_TST_CLEAR ##1 count == 16'h0000)
    else $error("clear failed");

  // load presets the shown decades at state seven
  load_a: assert property (ce && !load_b |-> tdec == `GFC_TST_LOAD ##1 count == PRESET)
    else $error("preset load failed");

  // clear and load never while counting
  pulse_quiet_a: assert property (clear || !load_b |-> !gate)
    else $error("clear or load while counting");

  // main scenarios
  cov_latch_c: cover property (latch_en ##1 !latch_en);
  cov_load_c: cover property (clear ##[1:200] !load_b);
  cov_gate_c: cover property (!gate ##1 gate);
  cov_carry_c: cover property (dig_inc[NDIG]);

endmodule

/* File: gfc_lo_model.sv */
// Purpose: model of the squared oscillator pick-off that feeds lo_in
// Assumes: driven on the falling edge of mclk
// Notes: the oscillator runs whatever the gate does, so the model never looks at it
`timescale 1ns/1ps

module gfc_lo_model (
  input wire logic mclk,
  output logic lo_in
);
  initial lo_in = 1'b0;

  // one pulse is one cycle high then one cycle low
  task automatic send(input int n);
    repeat (n) begin
      @(negedge mclk);
      lo_in = 1'b1;
      @(negedge mclk);
      lo_in = 1'b0;
    end
  endtask
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the gated frequency counter
// Assumes: reference edge every 8 mclk cycles, so one gate half is 1280 cycles
// Notes: inputs change on the falling edge, outputs are sampled there too
`timescale 1ns/1ps

module tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic ref_in = 1'b0;
  logic ref_run = 1'b0;
  logic lo_in;
  logic gate;
  gfc_pkg::gfc_pulse_s pulse;
  logic [15:0] disp;
  logic [3:0] timing_state;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  always #10 mclk = ~mclk;

  gfc_top gfc_top_i (.mclk(mclk), .rst_b(rst_b), .ce(ce), .ref_in(ref_in), .lo_in(lo_in), .gate(gate),
    .pulse(pulse), .disp(disp), .timing_state(timing_state));
  gfc_lo_model gfc_lo_model_i (.mclk(mclk), .lo_in(lo_in));

  // reference toggles every 4 cycles once running
  always begin
    repeat (4) @(negedge mclk);
    if (ref_run) ref_in = ~ref_in;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // pulses decoded from the timing state, only in the quiet half
  task automatic check_pulses();
    logic q;
    q = (gate === 1'b0);
    check("latch_en", 16'(pulse.latch_en), 16'(q && timing_state === 4'h3));
    check("clear", 16'(pulse.clear), 16'(q && timing_state === 4'h5));
    check("load_b", 16'(pulse.load_b), 16'(!(q && timing_state === 4'h7)));
  endtask

  // follows the chain until the gate reaches lvl, counting cycles
  task automatic wait_gate(input logic lvl, output int cyc);
    logic [3:0] prev;
    prev = timing_state;
    cyc = 0;
    while (gate !== lvl && cyc < 3000) begin
      @(negedge mclk);
      check_pulses();
      if (timing_state !== prev) check("timing step", 16'(timing_state), 16'(prev == 4'h9 ? 4'h0 : prev + 4'h1));
      prev = timing_state;
      cyc++;
    end
    check("gate level", 16'(gate), 16'(lvl));
    check("state at gate edge", 16'(timing_state), 16'h0000);
  endtask

  task automatic t_reset();
    check("gate in reset", 16'(gate), 16'h0000);
    check("disp in reset", disp, 16'h0000);
    check("state in reset", 16'(timing_state), 16'h0000);
    check("pulses in reset", 16'(pulse), 16'h0001);
    $display("test reset done");
  endtask

  // first quiet half latches zeros, then clears and presets
  task automatic t_first_quiet();
    wait_gate(1'b1, n);
    check("disp after first quiet", disp, 16'h0000);
    $display("test first quiet done");
  endtask

  // counts pulses in the high half, ignores pulses in the quiet half
  task automatic t_count(input int pulses, input logic [15:0] exp);
    logic [15:0] held;
    held = disp;
    fork
      gfc_lo_model_i.send(pulses);
      wait_gate(1'b0, n);
    join
    check("counting half length", 16'(n), 16'h0500);
    check("disp frozen while counting", disp, held);
    fork
      gfc_lo_model_i.send(20);
      wait_gate(1'b1, n);
    join
    check("quiet half length", 16'(n), 16'h0500);
    check("disp after update", disp, exp);
    $display("test count of %0d pulses done", pulses);
  endtask

  // clock enable low freezes the timing chain and hides pulses sent while counting
  task automatic t_ce();
    logic [3:0] ts;
    logic g;
    ts = timing_state;
    g = gate;
    ce = 1'b0;
    gfc_lo_model_i.send(100);
    repeat (100) @(negedge mclk);
    check("frozen state", 16'(timing_state), 16'(ts));
    check("frozen gate", 16'(gate), 16'(g));
    ce = 1'b1;
    wait_gate(1'b0, n);
    wait_gate(1'b1, n);
    check("quiet half after enable", 16'(n), 16'h0500);
    check("disp without frozen pulses", disp, 16'h9545);
    $display("test clock enable done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence: 95450 + 553 tenths shows 9600, residue 3 + 7 shows 9546
  initial begin
    repeat (4) @(negedge mclk);
    t_reset();
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    ref_run = 1'b1;
    t_first_quiet();
    t_count(553, 16'h9600);
    t_count(7, 16'h9546);
    t_ce();
    report_and_stop();
  end

  // watchdog well beyond the roughly 10000 cycles the tests need
  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
